// ### logic/laser_seq_pkg.sv
// Constants shared by the laser status and fault sequencer.
// Assumes a single 125 MHz clock and 32-bit APB register access.
package laser_seq_pkg;
  // Clock rate and derived per-millisecond count.
  localparam int CLK_HZ = 125_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // Start-up, shutter and blink timing in their own units.
  localparam int ARM_DELAY_MS = 5000;
  localparam int GATE_DELAY_MS = 5000;
  localparam int BLINK_MS = 500;
  localparam int PAUSE_MS = 4000;
  localparam int ARM_DELAY_CYC = ARM_DELAY_MS * CYC_PER_MS;
  localparam int GATE_DELAY_CYC = GATE_DELAY_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int PAUSE_SLOTS = PAUSE_MS / BLINK_MS;
  // PWM limits: frequency, duty, pulse width, no-strike duty, lase threshold.
  localparam int FREQ_LIMIT_KHZ = 100;
  localparam int FREQ_PERIOD_CYC = CLK_HZ / (FREQ_LIMIT_KHZ * 1000);
  localparam int DUTY_LIMIT_PCT = 50;
  localparam int PULSE_LIMIT_US = 500;
  localparam int PULSE_LIMIT_CYC = PULSE_LIMIT_US * CYC_PER_US;
  localparam int STRIKE_LIMIT_PCT = 5;
  localparam int LASE_MIN_NS = 1000;
  localparam int LASE_MIN_CYC = (LASE_MIN_NS * CYC_PER_US + 999) / 1000;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
  // Field positions.
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_GATE_BIT = 1;
  localparam int ST_RF_BIT = 2;
  localparam int ST_TICKLE_BIT = 3;
  localparam int ST_NOSTRIKE_BIT = 4;
  localparam int ST_FREQ_BIT = 5;
  localparam int ST_DUTY_BIT = 6;
  localparam int ST_CODE_LSB = 8;
  localparam int IRQ_BITS = 5;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 5'h00;
  // Readiness sequence states.
  typedef enum logic [1:0] {DISARMED, ARM_WAIT, ARMED} arm_state_t;
endpackage

// ### logic/laser_status_fault_sequencer.sv
// Status and fault sequencer: RF gating, start-up delays, lamps, user outputs.
// Assumes inputs synchronous to pclk and fault flags already qualified.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Keyswitch: armed lights only with interlock, thermal good and key off-to-on or a start request with key on.
// - Keyswitch: five-second wait after armed lamp before lasing.
// - Keyswitch: gate-open needs shutter request and manual switch open.
// - Keyswitch: armed and shutter opening: PWM ignored for five seconds.
// - Emission lamp lights while PWM pulses long enough to lase.
// - OEM: armed lights at power-up once interlock and thermal good.
// - OEM: lasing allowed at once when armed and gate-open.
// - RF drive off unless armed and gate-open both active.
// - Fault code blinks armed lamp N times, pauses four seconds, repeats.
// - Fault blinking persists until reset by power cycle.
// - No-strike flashes gate lamp, limits duty to 5%, self-recovers.
// - Under-voltage one blink, over-voltage two blinks, RF removed.
// - RF switch fault three blinks, PWM drive fault four blinks.
// - Pulsed: frequency fault at 100 kHz or more, clears below.
// - Pulsed: fault at 50% duty or 500 us pulse, clears below.
// - Keyswitch: tickle for five seconds on enabling before PWM firing.
// - User outputs closed while their named condition is true.
// - OEM: interlock fault not latched, readiness returns at once.
module laser_status_fault_sequencer
  import laser_seq_pkg::*;
#(
  parameter int ARM_DELAY = ARM_DELAY_CYC,
  parameter int GATE_DELAY = GATE_DELAY_CYC,
  parameter int BLINK = BLINK_CYC,
  parameter int PULSE_LIMIT = PULSE_LIMIT_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Variant straps
  input wire logic oem_variant,
  input wire logic pulsed_variant,
  // Machine controller inputs
  input wire logic interlock_ok,
  input wire logic keyswitch_on,
  input wire logic reset_start_req,
  input wire logic shutter_req,
  input wire logic shutter_switch_open,
  input wire logic pwm_cmd,
  // Fault flags from sensing
  input wire logic thermal_ok,
  input wire logic under_voltage,
  input wire logic over_voltage,
  input wire logic rf_switch_fault,
  input wire logic pwm_drive_fault,
  input wire logic no_strike,
  // Lamps and drive
  output logic interlock_lamp,
  output logic thermal_lamp,
  output logic armed_lamp,
  output logic gate_open_lamp,
  output logic emission_lamp,
  output logic rf_drive,
  output logic tickle_active,
  // User status outputs, high means closed
  output logic interlock_open_out,
  output logic fault_detected_out,
  output logic laser_ready_out,
  output logic shutter_open_out,
  output logic lase_active_out
);

  // Length of one code frame in 500 ms slots: blinks then the pause.
  function automatic logic [4:0] frame_len(input logic [2:0] code);
    frame_len = 5'({code, 1'b0}) + 5'(PAUSE_SLOTS);
  endfunction

  // Lamp level for a slot of a code frame.
  function automatic logic blink_on(input logic [2:0] code, input logic [4:0] slot);
    blink_on = (code != 3'h0) && (slot < 5'({code, 1'b0})) && !slot[0];
  endfunction

  logic strap_taken, oem, pulsed;
  arm_state_t state;
  logic [31:0] arm_cnt, gate_cnt, blink_cnt, period_cnt, high_cnt, last_period;
  logic key_q, pwm_q, gate_q, gate_ok, thermal_bad, blink_tick, flash_ph;
  logic freq_lim, duty_lim;
  logic [2:0] fault_code;
  logic [4:0] slot [2];
  logic [2:0] codes [2];
  logic [31:0] ctrl;
  logic [IRQ_BITS-1:0] irq_stat, irq_mask, events;
  logic good, armed_ind, permit, next_rf, next_gate, strike_ok;
  logic [2:0] next_code;
  logic ap_access, ap_setup, wr;
  logic [31:0] next_rdata;

  // Variant straps are caught on the first edge after reset release.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken <= 1'b0;
      oem <= 1'b0;
      pulsed <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      oem <= oem_variant;
      pulsed <= pulsed_variant;
    end
  end

  // Fault code priority: lowest code wins when several appear together.
  always_comb begin
    next_code = 3'h0;
    if (pwm_drive_fault) next_code = 3'h4;
    if (rf_switch_fault) next_code = 3'h3;
    if (over_voltage) next_code = 3'h2;
    if (under_voltage) next_code = 3'h1;
  end

  // Latched until reset. The code only clears at power cycle, even when
  // the cause goes away, so an intermittent supply never re-arms itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_code <= 3'h0;
      thermal_bad <= 1'b0;
    end else begin
      if (fault_code == 3'h0 && strap_taken) fault_code <= next_code;
      if (!thermal_ok && strap_taken) thermal_bad <= 1'b1;
    end
  end

  assign good = interlock_ok && !thermal_bad && (fault_code == 3'h0);
  assign armed_ind = (state != DISARMED);

  // Readiness sequence.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DISARMED;
      arm_cnt <= 32'h0000_0000;
      key_q <= 1'b0;
    end else begin
      key_q <= keyswitch_on;
      case (state)
        DISARMED: begin
          arm_cnt <= 32'h0000_0000;
          if (strap_taken && oem && good) begin
            state <= ARMED;
          end else if (strap_taken && !oem && good &&
                       ((keyswitch_on && !key_q) || (reset_start_req && keyswitch_on))) begin
            state <= ARM_WAIT;
          end
        end
        ARM_WAIT: begin
          arm_cnt <= arm_cnt + 32'h0000_0001;
          if (!good || !keyswitch_on) begin
            state <= DISARMED;
          end else if (arm_cnt >= 32'(ARM_DELAY - 1)) begin
            state <= ARMED;
          end
        end
        ARMED: begin
          if (!good || (!oem && !keyswitch_on)) state <= DISARMED;
        end
        default: state <= DISARMED;
      endcase
    end
  end

  assign next_gate = shutter_req && (oem || shutter_switch_open);

  // Shutter delay; the tickle phase is the same window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_q <= 1'b0;
      gate_cnt <= 32'h0000_0000;
      gate_ok <= 1'b0;
      tickle_active <= 1'b0;
    end else begin
      gate_q <= next_gate;
      if (!gate_q || !armed_ind || oem) begin
        gate_cnt <= 32'h0000_0000;
      end else if (!gate_ok) begin
        gate_cnt <= gate_cnt + 32'h0000_0001;
      end
      gate_ok <= gate_q && armed_ind &&
                 (oem || gate_cnt >= 32'(GATE_DELAY - 1));
      tickle_active <= gate_q && armed_ind && !oem && !gate_ok;
    end
  end

  // PWM period and pulse measurement; counters saturate when input is idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_q <= 1'b0;
      period_cnt <= 32'h0000_0000;
      high_cnt <= 32'h0000_0000;
      last_period <= 32'h0000_0000;
      freq_lim <= 1'b0;
      duty_lim <= 1'b0;
    end else begin
      pwm_q <= pwm_cmd;
      if (pwm_cmd && !pwm_q) begin
        period_cnt <= 32'h0000_0001;
        high_cnt <= 32'h0000_0001;
        last_period <= period_cnt;
        freq_lim <= pulsed && (period_cnt <= 32'(FREQ_PERIOD_CYC));
        duty_lim <= pulsed && ((32'(high_cnt * 100) >= 32'(period_cnt * DUTY_LIMIT_PCT)) ||
                               (high_cnt >= 32'(PULSE_LIMIT)));
      end else begin
        if (period_cnt != 32'hFFFF_FFFF) period_cnt <= period_cnt + 32'h0000_0001;
        if (pwm_cmd && high_cnt != 32'hFFFF_FFFF) high_cnt <= high_cnt + 32'h0000_0001;
        if (pulsed && pwm_cmd && high_cnt >= 32'(PULSE_LIMIT)) duty_lim <= 1'b1;
      end
    end
  end

  // Five percent limit. The ratio uses the previous period, so the first
  // pulse after a pause is judged against the long idle gap and may run longer.
  assign strike_ok = !no_strike ||
                     (32'(high_cnt * 100) < 32'(last_period * STRIKE_LIMIT_PCT));

  assign permit = (state == ARMED) && gate_q && gate_ok && !ctrl[CTRL_INHIBIT_BIT] &&
                  (fault_code == 3'h0) && !freq_lim && !duty_lim;
  assign next_rf = permit && pwm_cmd && strike_ok;

  // Blink time base and per-lamp frame slots.
  assign codes[0] = fault_code;
  assign codes[1] = freq_lim ? 3'h2 : (duty_lim ? 3'h3 : 3'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 32'h0000_0000;
      blink_tick <= 1'b0;
      flash_ph <= 1'b0;
      for (int i = 0; i < 2; i++) slot[i] <= 5'h00;
    end else begin
      blink_tick <= (blink_cnt == 32'(BLINK - 2));
      blink_cnt <= (blink_cnt >= 32'(BLINK - 1)) ? 32'h0000_0000 : blink_cnt + 32'h0000_0001;
      if (blink_tick) flash_ph <= !flash_ph;
      for (int i = 0; i < 2; i++) begin
        if (codes[i] == 3'h0) begin
          slot[i] <= 5'h00;
        end else if (blink_tick) begin
          slot[i] <= (slot[i] >= frame_len(codes[i]) - 5'h01) ? 5'h00 : slot[i] + 5'h01;
        end
      end
    end
  end

  // Lamps, drive and user outputs, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interlock_lamp <= 1'b0;
      thermal_lamp <= 1'b0;
      armed_lamp <= 1'b0;
      gate_open_lamp <= 1'b0;
      emission_lamp <= 1'b0;
      rf_drive <= 1'b0;
      interlock_open_out <= 1'b0;
      fault_detected_out <= 1'b0;
      laser_ready_out <= 1'b0;
      shutter_open_out <= 1'b0;
      lase_active_out <= 1'b0;
    end else begin
      interlock_lamp <= interlock_ok;
      thermal_lamp <= !thermal_bad;
      armed_lamp <= (fault_code != 3'h0) ? blink_on(codes[0], slot[0]) : armed_ind;
      gate_open_lamp <= no_strike ? flash_ph :
                        ((codes[1] != 3'h0) ? blink_on(codes[1], slot[1]) : gate_q);
      rf_drive <= next_rf;
      emission_lamp <= next_rf && (high_cnt >= 32'(LASE_MIN_CYC));
      interlock_open_out <= !interlock_ok;
      fault_detected_out <= thermal_bad || (fault_code != 3'h0) || no_strike ||
                            freq_lim || duty_lim;
      laser_ready_out <= armed_ind;
      shutter_open_out <= gate_q;
      lase_active_out <= next_rf && (high_cnt >= 32'(LASE_MIN_CYC));
    end
  end

  // APB: one-cycle answer, write takes effect on the access edge.
  assign ap_setup = psel && !penable;
  assign ap_access = psel && penable && pready;
  assign wr = ap_access && pwrite;
  assign events = {duty_lim, freq_lim, no_strike, (fault_code != 3'h0),
                   (state == ARMED)};

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      CTRL_OFS: next_rdata = ctrl;
      STATUS_OFS: begin
        next_rdata[ST_ARMED_BIT] = armed_ind;
        next_rdata[ST_GATE_BIT] = gate_q;
        next_rdata[ST_RF_BIT] = rf_drive;
        next_rdata[ST_TICKLE_BIT] = tickle_active;
        next_rdata[ST_NOSTRIKE_BIT] = no_strike;
        next_rdata[ST_FREQ_BIT] = freq_lim;
        next_rdata[ST_DUTY_BIT] = duty_lim;
        next_rdata[ST_CODE_LSB +: 3] = fault_code;
      end
      IRQ_STAT_OFS: next_rdata[IRQ_BITS-1:0] = irq_stat;
      IRQ_MASK_OFS: next_rdata[IRQ_BITS-1:0] = irq_mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus answer path; unmapped addresses read zero with an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= ap_setup;
      pslverr <= ap_setup && (paddr > IRQ_MASK_OFS || paddr[1:0] != 2'h0);
      prdata <= ap_setup ? next_rdata : 32'h0000_0000;
    end
  end

  // Registers; status bits are levels that set, writing one clears, set wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      irq_mask <= IRQ_MASK_RST;
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr && paddr == CTRL_OFS) ctrl <= {31'h0000_0000, pwdata[CTRL_INHIBIT_BIT]};
      if (wr && paddr == IRQ_MASK_OFS) irq_mask <= pwdata[IRQ_BITS-1:0];
      irq_stat <= (irq_stat & ~((wr && paddr == IRQ_STAT_OFS) ?
                   pwdata[IRQ_BITS-1:0] : 5'h00)) | events;
      irq <= |(irq_stat & irq_mask);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_rf_gated;
    rf_drive |-> $past(state == ARMED && gate_q && gate_ok);
  endproperty
  a_rf_gated: assert property (p_rf_gated) else $error("RF drive without armed and gate");

  property p_fault_no_rf;
    (fault_code != 3'h0) |=> !rf_drive;
  endproperty
  a_fault_no_rf: assert property (p_fault_no_rf) else $error("RF drive during fault");

  property p_key_arm;
    $rose(armed_ind) && !oem |-> $past(good && keyswitch_on);
  endproperty
  a_key_arm: assert property (p_key_arm) else $error("Armed without keyswitch on and good");

  property p_arm_wait;
    $rose(armed_ind) && !oem |=> (state != ARMED) [*2];
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("Lasing allowed without delay");

  property p_oem_arm;
    strap_taken && oem && good && state == DISARMED |=> state == ARMED;
  endproperty
  a_oem_arm: assert property (p_oem_arm) else $error("OEM did not arm at once");

  property p_gate_hold;
    $rose(gate_q) && armed_ind && !oem |=> !gate_ok [*2];
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("PWM recognised too soon");

  property p_code_sticky;
    (fault_code != 3'h0) |=> $stable(fault_code);
  endproperty
  a_code_sticky: assert property (p_code_sticky) else $error("Fault code changed");

  property p_slot_range;
    slot[0] < frame_len(codes[0]) || codes[0] == 3'h0;
  endproperty
  a_slot_range: assert property (p_slot_range) else $error("Blink slot past frame");

  property p_user_out;
    ##1 interlock_open_out == !$past(interlock_ok) && shutter_open_out == $past(gate_q);
  endproperty
  a_user_out: assert property (p_user_out) else $error("User output mismatch");

  property p_freq;
    $rose(freq_lim) |-> $past(pwm_cmd && !pwm_q && pulsed);
  endproperty
  a_freq: assert property (p_freq) else $error("Frequency limit outside an edge");

  c_firing: cover property (rf_drive ##1 emission_lamp);
  c_code_blink: cover property ((fault_code == 3'h2) && $rose(armed_lamp));
  c_irq: cover property ($rose(irq));
  c_nostrike: cover property (no_strike && rf_drive);

endmodule

`default_nettype wire

// ### tb/machine_ctrl_model.sv
// Machine controller model: drives the PWM command line.
// Assumes pclk and the active-low reset from the bench.
`timescale 1ns/10ps
`default_nettype none
module machine_ctrl_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Waveform shape in clock cycles
  input wire logic [15:0] period,
  input wire logic [15:0] high_time,
  // Command line
  output logic pwm_cmd
);
  logic [15:0] cnt;
  // Free-running period; a high time at or above the period gives a steady level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0000;
      pwm_cmd <= 1'b0;
    end else begin
      cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
      pwm_cmd <= (cnt < high_time);
    end
  end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the laser status and fault sequencer.
// Assumes the controller model is compiled first; delays are shortened.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import laser_seq_pkg::*;
  localparam int BL = 8;
  localparam int A = 0, G = 1, E = 2, T = 3, RF = 4, IQ = 5, IO = 6, LR = 7, SO = 8, LA = 9;
  localparam int FD = 10, IL = 11, TL = 12;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oem, pulsed, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ilk, key, rst_req, sh_req, sh_sw, pwm, thermal, nostrike;
  logic [3:0] flt;
  logic [15:0] per, hi;
  wire [12:0] obs;
  int cyc = 0;
  int n_fail = 0;
  int checks_done = 0;

  laser_status_fault_sequencer #(.ARM_DELAY(20), .GATE_DELAY(20), .BLINK(BL),
    .PULSE_LIMIT(1000)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(obs[IQ]), .oem_variant(oem), .pulsed_variant(pulsed), .interlock_ok(ilk),
    .keyswitch_on(key), .reset_start_req(rst_req), .shutter_req(sh_req),
    .shutter_switch_open(sh_sw), .pwm_cmd(pwm), .thermal_ok(thermal),
    .under_voltage(flt[0]), .over_voltage(flt[1]), .rf_switch_fault(flt[2]),
    .pwm_drive_fault(flt[3]), .no_strike(nostrike), .interlock_lamp(obs[IL]),
    .thermal_lamp(obs[TL]), .armed_lamp(obs[A]), .gate_open_lamp(obs[G]),
    .emission_lamp(obs[E]), .rf_drive(obs[RF]), .tickle_active(obs[T]),
    .interlock_open_out(obs[IO]), .fault_detected_out(obs[FD]), .laser_ready_out(obs[LR]),
    .shutter_open_out(obs[SO]), .lase_active_out(obs[LA]));

  machine_ctrl_model i_ctrl (.pclk(pclk), .presetn(presetn), .period(per),
    .high_time(hi), .pwm_cmd(pwm));

  // Clock; the cycle ceiling guards against a hang.
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so no signal is driven twice at one edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic reach(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, obs[i]}, {31'h0, v}, $sformatf("output %0d late", i));
  endtask

  task automatic stays(input int i, input logic v, input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(posedge pclk);
      if (obs[i] !== v) bad++;
    end
    chk(bad, 0, $sformatf("output %0d moved", i));
  endtask

  // Two whole code periods hold exactly two codes' worth of blinks at any phase.
  task automatic blinks(input int code);
    int r;
    logic p;
    r = 0;
    p = obs[A];
    repeat (2 * (2 * code + 8) * BL) begin
      @(posedge pclk);
      if (obs[A] === 1'b1 && p === 1'b0) r++;
      p = obs[A];
    end
    chk(r, 2 * code, "blink count");
  endtask

  task automatic do_reset(input logic o, input logic p, input logic k);
    presetn <= 1'b0;
    oem <= o;
    pulsed <= p;
    key <= k;
    ilk <= 1'b1;
    thermal <= 1'b1;
    flt <= 4'h0;
    nostrike <= 1'b0;
    sh_req <= 1'b0;
    sh_sw <= 1'b0;
    per <= 16'h0002;
    hi <= 16'h0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic s_regs();
    do_reset(1'b0, 1'b0, 1'b0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, CTRL_RST, "ctrl reset");
    apb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk(rd, {27'h0, IRQ_MASK_RST}, "mask reset");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'h05, 32'h1);
    chk({31'h0, err}, 32'h1, "unaligned");
  endtask

  task automatic s_key();
    do_reset(1'b0, 1'b0, 1'b0);
    hi <= 16'h0002;
    sh_req <= 1'b1;
    stays(A, 1'b0, 10); // no key step yet.
    key <= 1'b1;
    reach(A, 1'b1, 5); // armed after key.
    reach(LR, 1'b1, 3); // ready closed.
    stays(G, 1'b0, 8); // switch still shut.
    sh_sw <= 1'b1;
    reach(G, 1'b1, 4); // gate lamp lit.
    reach(T, 1'b1, 4); // tickle on.
    stays(RF, 1'b0, 12); // PWM ignored.
    reach(RF, 1'b1, 40); // drive follows PWM.
    reach(SO, 1'b1, 3); // shutter closed.
    reach(E, 1'b1, 140); // emission lit.
    reach(LA, 1'b1, 3); // lase closed.
    nostrike <= 1'b1;
    reach(RF, 1'b0, 4); // long pulse cut.
    reach(FD, 1'b1, 3); // fault closed.
    nostrike <= 1'b0;
    reach(RF, 1'b1, 4); // recovers without reset.
    apb(1'b1, CTRL_OFS, 32'h1);
    reach(RF, 1'b0, 4);
    apb(1'b1, CTRL_OFS, 32'h0);
    reach(RF, 1'b1, 4);
    apb(1'b1, IRQ_MASK_OFS, 32'h1);
    reach(IQ, 1'b1, 4);
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    reach(IQ, 1'b0, 4);
    hi <= 16'h0000;
    reach(E, 1'b0, 4); // dark without pulses.
    hi <= 16'h0002;
    reach(RF, 1'b1, 4);
    sh_req <= 1'b0;
    reach(RF, 1'b0, 6); // gate closed removes drive.
    ilk <= 1'b0;
    reach(IO, 1'b1, 4); // interlock open closed.
    reach(A, 1'b0, 4); // readiness lost.
  endtask

  task automatic s_nostrike();
    do_reset(1'b0, 1'b0, 1'b1);
    nostrike <= 1'b1;
    reach(G, 1'b1, 2 * BL + 4); // lamp flashes.
    reach(G, 1'b0, 2 * BL + 4); // lamp flashes.
    reach(G, 1'b1, 2 * BL + 4); // lamp flashes.
    apb(1'b1, IRQ_MASK_OFS, 32'h4);
    reach(IQ, 1'b1, 4);
    nostrike <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, IRQ_STAT_OFS, 32'h4);
    reach(IQ, 1'b0, 4);
    stays(G, 1'b0, 3 * BL); // recovery without reset.
  endtask

  task automatic s_codes();
    for (int c = 1; c <= 4; c++) begin
      do_reset(1'b0, 1'b0, 1'b1);
      sh_req <= 1'b1;
      sh_sw <= 1'b1;
      hi <= 16'h0002;
      // A key held on through reset is no off-to-on step; arm by a start request.
      rst_req <= 1'b1;
      @(posedge pclk);
      rst_req <= 1'b0;
      stays(RF, 1'b0, 15); // start-up hold.
      reach(RF, 1'b1, 60); // fires once armed.
      flt <= 4'(1 << (c - 1));
      repeat (2) @(posedge pclk);
      flt <= 4'h0;
      reach(RF, 1'b0, 4); // drive removed.
      repeat (4) @(posedge pclk);
      blinks(c); // code repeats after cause is gone.
    end
  endtask

  task automatic s_pulsed();
    int pr[6] = '{1250, 1251, 1300, 1300, 3000, 3000};
    int ht[6] = '{10, 10, 650, 649, 1000, 999};
    logic [1:0] ex[6] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b10, 2'b00};
    do_reset(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      per <= 16'(pr[i]);
      hi <= 16'(ht[i]);
      repeat (4 * pr[i]) @(posedge pclk);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk({30'h0, rd[ST_DUTY_BIT], rd[ST_FREQ_BIT]}, {30'h0, ex[i]}, "limits");
    end
  endtask

  task automatic s_oem();
    do_reset(1'b1, 1'b0, 1'b0);
    sh_req <= 1'b1;
    hi <= 16'h0002;
    reach(A, 1'b1, 5); // armed without key.
    reach(RF, 1'b1, 6); // no added delay.
    ilk <= 1'b0;
    reach(A, 1'b0, 4); // readiness follows interlock.
    reach(IL, 1'b0, 3); // interlock lamp dark.
    ilk <= 1'b1;
    reach(A, 1'b1, 4); // not latched.
    reach(RF, 1'b1, 6); // fires at once.
    thermal <= 1'b0;
    reach(TL, 1'b0, 4); // thermal lamp dark.
    reach(A, 1'b0, 4); // armed needs thermal good.
    reach(FD, 1'b1, 3); // fault closed.
    thermal <= 1'b1;
    stays(A, 1'b0, 8); // over-temperature held until reset.
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_req = 1'b0;
    s_regs();
    s_key();
    s_nostrike();
    s_codes();
    s_pulsed();
    s_oem();
    conclude();
  end
endmodule
`default_nettype wire
